// >>> src/sac_consts.vh
// Purpose: shared constants of the converter sequencer
// Assumes: included by every design file of the block
// Notes: definitions only
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH
// ==========================================================
// Resolution codes and conversion lengths in conversion clocks
`define SAC_RES_8 2'b00
`define SAC_RES_10 2'b01
`define SAC_RES_12 2'b10
`define SAC_CYC_8 5'd10
`define SAC_CYC_10 5'd12
`define SAC_CYC_12 5'd14
`define SAC_SAMPLE_CYC 5'd2
// ==========================================================
// Memory control entry layout
`define SAC_ENT_CH_LSB 0
`define SAC_ENT_CH_MSB 4
`define SAC_ENT_DIFF 5
`define SAC_ENT_REF_LSB 6
`define SAC_ENT_REF_MSB 7
`define SAC_ENT_EOS 8
`define SAC_ENT_RST 9'h000
`define SAC_REF_SUPPLY 2'b00
// ==========================================================
// Interrupt vector codes, memory entry k reads MEM0 + 2k
`define SAC_IV_NONE 8'h00
`define SAC_IV_ABOVE 8'h02
`define SAC_IV_BELOW 8'h04
`define SAC_IV_IN 8'h06
`define SAC_IV_MEM0 8'h08
// ==========================================================
// Sizes and reset values
`define SAC_NUM_ENT 32
`define SAC_CCLK_DIV 8
`define SAC_RES_RST 16'h0000
`endif

// >>> src/sac_sar_step.v
// Purpose: successive approximation step engine
// Assumes: comparator input already synchronised, high when input >= trial
// Notes: sample phase then one conversion clock per result bit
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_sar_step (
    input wire clk,
    input wire rst_b,
    input wire cclk_en,
    input wire go,
    input wire [1:0] res_sel,
    input wire comp,
    output wire sample_hold,
    output reg [11:0] trial,
    output reg [11:0] result,
    output reg busy,
    output reg done
);
    reg [4:0] cnt_q;
    reg [4:0] total_q;
    reg [3:0] nbits_q;
    reg [3:0] bit_q;
    reg [11:0] next_code;
    // ==========================================================
    // Trial decision for the current bit, next bit set as trial
    always @* begin
        next_code = comp ? trial : (trial & ~(12'h001 << bit_q));
        if (bit_q > (4'd12 - nbits_q)) begin
            next_code = next_code | (12'h001 << (bit_q - 4'd1));
        end
    end
    assign sample_hold = busy && (cnt_q < `SAC_SAMPLE_CYC);
    // ==========================================================
    // Conversion sequencing on conversion clock ticks
    always @(posedge clk) begin
        done <= 1'b0;
        if (!rst_b) begin
            cnt_q <= 5'd0;
            total_q <= `SAC_CYC_12;
            nbits_q <= 4'd12;
            bit_q <= 4'd11;
            trial <= 12'h000;
            result <= 12'h000;
            busy <= 1'b0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            cnt_q <= 5'd0;
            trial <= 12'h000;
            // Length follows resolution
            case (res_sel)
                `SAC_RES_8: begin
                    total_q <= `SAC_CYC_8;
                    nbits_q <= 4'd8;
                end
                `SAC_RES_10: begin
                    total_q <= `SAC_CYC_10;
                    nbits_q <= 4'd10;
                end
                default: begin
                    total_q <= `SAC_CYC_12;
                    nbits_q <= 4'd12;
                end
            endcase
        end else if (busy && cclk_en) begin
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == `SAC_SAMPLE_CYC - 5'd1) begin
                trial <= 12'h800;
                bit_q <= 4'd11;
            end else if (cnt_q >= `SAC_SAMPLE_CYC) begin
                trial <= next_code;
                bit_q <= bit_q - 4'd1;
                if (cnt_q == total_q - 5'd1) begin
                    // Right justify at the chosen width
                    result <= next_code >> (4'd12 - nbits_q);
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> src/sac_ctrl.v
// Purpose: sequencer, result store, window compare and vector of the converter
// Assumes: conversion clock is an enable from a divider of clk
// Notes: thresholds and results share the units of the chosen resolution
// Operation
// - Conversion lasts 10, 12 or 14 conversion clocks for 8, 10, 12 bits
// - Result width 8, 10 or 12 bits from resolution select
// - Window enabled and result between thresholds raises in-window flag
// - Results above high or below low raise their own flags
// - Thresholds compare directly against raw result codes
// - One threshold pair applies to every channel
// - 32 memory entries, each with result buffer and own flag
// - Each entry carries channel and reference choice used for it
// - Group results land in consecutive buffers, readable when group ends
// - Format select gives two's complement, otherwise unsigned
// - Low power mode bit; software uses it only below 50 ksps
// - One vector word reports the highest priority pending source
// - 16 single ended inputs, pairable into 8 differential
// - With window enabled, every result is dropped and only the window flags record it
// - Results move to memory through the system DMA, by request
// - Reference ready flag is waited for before relying on it
// - Reference busy flag is high while the converter uses it
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_ctrl #(
    parameter CCLK_DIV = `SAC_CCLK_DIV
) (
    input wire clk,
    input wire rst_b,
    input wire conv_start,
    input wire seq_group,
    input wire [4:0] seq_first,
    input wire [1:0] resolution_select,
    input wire result_format_select,
    input wire low_rate_power_mode,
    input wire win_enable,
    input wire [11:0] win_high,
    input wire [11:0] win_low,
    input wire ent_wr,
    input wire [4:0] ent_idx,
    input wire [8:0] ent_wdata,
    input wire [31:0] interrupt_enable_low,
    input wire [2:0] interrupt_enable_high,
    input wire rd_stb,
    input wire [4:0] rd_idx,
    output reg [15:0] rd_data,
    input wire iv_rd_stb,
    output reg [7:0] converter_interrupt_vector,
    output wire [31:0] interrupt_flag_low,
    output wire [2:0] interrupt_flag_high,
    output wire irq,
    input wire comp_in,
    input wire reference_ready_flag,
    output reg reference_busy_flag,
    output wire sample_hold,
    output wire [11:0] dac_code,
    output reg [3:0] mux_pos,
    output reg [3:0] mux_neg,
    output reg mux_diff,
    output reg mux_internal,
    output reg [1:0] ref_sel,
    output reg low_power_bias,
    output reg dma_req,
    output wire busy,
    output reg seq_done
);
    // ==========================================================
    // State machine codes
    localparam ST_IDLE = 2'b00;
    localparam ST_WREF = 2'b01;
    localparam ST_CONV = 2'b10;
    localparam DIV_W = 8;

    reg [1:0] state_q;
    reg [4:0] cur_q;
    reg group_q;
    reg [1:0] res_q;
    reg df_q;
    reg go_q;
    reg [DIV_W-1:0] div_q;
    reg cclk_en;
    reg [8:0] ent_q [0:`SAC_NUM_ENT-1];
    reg [15:0] res_mem_q [0:`SAC_NUM_ENT-1];
    reg [31:0] mem_flag_q;
    reg [2:0] win_flag_q;
    reg [2:0] comp_s_q;
    reg comp_f_q;
    reg [2:0] rdy_s_q;
    reg rdy_f_q;
    wire [11:0] raw;
    wire sar_done;
    wire sar_busy;
    wire [8:0] cur_ent;
    wire [34:0] pending;
    wire is_above;
    wire is_below;
    wire wr_result;
    wire [15:0] fmt_result;
    integer i_ent;
    integer i_res;
    integer i_win;

    // ==========================================================
    // Functions
    // Width in bits for a resolution code
    function [3:0] res_bits;
        input [1:0] sel;
        begin
            case (sel)
                `SAC_RES_8: res_bits = 4'd8;
                `SAC_RES_10: res_bits = 4'd10;
                default: res_bits = 4'd12;
            endcase
        end
    endfunction

    // Offset binary to sign extended two's complement when df is set
    function [15:0] fmt_code;
        input [11:0] code;
        input [3:0] nbits;
        input df;
        reg [15:0] u;
        reg [15:0] msb;
        begin
            u = {4'h0, code};
            msb = 16'h0001 << (nbits - 4'd1);
            if (df) begin
                u = u ^ msb;
                if ((u & msb) != 16'h0000) begin
                    u = u | ~(msb - 16'h0001);
                end
            end
            fmt_code = u;
        end
    endfunction

    // Vector code of the lowest numbered pending source
    function [7:0] iv_code;
        input [34:0] p;
        integer k;
        reg hit;
        begin
            iv_code = `SAC_IV_NONE;
            hit = 1'b0;
            for (k = 0; k < 35; k = k + 1) begin
                if (p[k] && !hit) begin
                    hit = 1'b1;
                    iv_code = `SAC_IV_ABOVE + 8'd2 * k[7:0];
                end
            end
        end
    endfunction

    // ==========================================================
    // Conversion clock enable from divider
    always @(posedge clk) begin
        if (!rst_b) begin
            div_q <= {DIV_W{1'b0}};
            cclk_en <= 1'b0;
        end else if (div_q == CCLK_DIV[DIV_W-1:0] - 8'd1) begin
            div_q <= {DIV_W{1'b0}};
            cclk_en <= 1'b1;
        end else begin
            div_q <= div_q + 8'd1;
            cclk_en <= 1'b0;
        end
    end

    // ==========================================================
    // Pin synchronisers, a change counts once stages two and three agree
    always @(posedge clk) begin
        if (!rst_b) begin
            comp_s_q <= 3'b000;
            comp_f_q <= 1'b0;
            rdy_s_q <= 3'b000;
            rdy_f_q <= 1'b0;
        end else begin
            comp_s_q <= {comp_s_q[1:0], comp_in};
            rdy_s_q <= {rdy_s_q[1:0], reference_ready_flag};
            if (comp_s_q[1] == comp_s_q[2]) begin
                comp_f_q <= comp_s_q[2];
            end
            if (rdy_s_q[1] == rdy_s_q[2]) begin
                rdy_f_q <= rdy_s_q[2];
            end
        end
    end

    // ==========================================================
    // Step engine
    sac_sar_step u_step (
        .clk(clk),
        .rst_b(rst_b),
        .cclk_en(cclk_en),
        .go(go_q),
        .res_sel(res_q),
        .comp(comp_f_q),
        .sample_hold(sample_hold),
        .trial(dac_code),
        .result(raw),
        .busy(sar_busy),
        .done(sar_done)
    );

    // ==========================================================
    // Memory control entries, written by software
    always @(posedge clk) begin
        if (!rst_b) begin
            for (i_ent = 0; i_ent < `SAC_NUM_ENT; i_ent = i_ent + 1) begin
                ent_q[i_ent] <= `SAC_ENT_RST;
            end
        end else if (ent_wr) begin
            ent_q[ent_idx] <= ent_wdata;
        end
    end
    assign cur_ent = ent_q[cur_q];

    // ==========================================================
    // Sequencer
    // Resolution and format are latched at start so a change mid group cannot split it
    always @(posedge clk) begin
        go_q <= 1'b0;
        seq_done <= 1'b0;
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cur_q <= 5'd0;
            group_q <= 1'b0;
            res_q <= `SAC_RES_12;
            df_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (conv_start) begin
                        cur_q <= seq_first;
                        group_q <= seq_group;
                        res_q <= resolution_select;
                        df_q <= result_format_select;
                        state_q <= ST_WREF;
                    end
                end
                ST_WREF: begin
                    // Internal reference must have settled
                    if (cur_ent[`SAC_ENT_REF_MSB:`SAC_ENT_REF_LSB] == `SAC_REF_SUPPLY ||
                        rdy_f_q) begin
                        go_q <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (sar_done) begin
                        // Walk consecutive entries until end mark
                        if (group_q && !cur_ent[`SAC_ENT_EOS] && cur_q != 5'd31) begin
                            cur_q <= cur_q + 5'd1;
                            state_q <= ST_WREF;
                        end else begin
                            seq_done <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // Step engine busy only ever overlaps the conversion state
    assign busy = (state_q != ST_IDLE) || sar_busy;

    // ==========================================================
    // Input mux and reference steering from the current entry
    // Channels 16 and up are internal sources, pairs are even and odd
    always @(posedge clk) begin
        if (!rst_b) begin
            mux_pos <= 4'h0;
            mux_neg <= 4'h0;
            mux_diff <= 1'b0;
            mux_internal <= 1'b0;
            ref_sel <= `SAC_REF_SUPPLY;
            reference_busy_flag <= 1'b0;
            low_power_bias <= 1'b0;
        end else begin
            mux_internal <= cur_ent[`SAC_ENT_CH_MSB];
            mux_diff <= cur_ent[`SAC_ENT_DIFF] && !cur_ent[`SAC_ENT_CH_MSB];
            if (cur_ent[`SAC_ENT_DIFF]) begin
                mux_pos <= {cur_ent[3:1], 1'b0};
                mux_neg <= {cur_ent[3:1], 1'b1};
            end else begin
                mux_pos <= cur_ent[3:0];
                mux_neg <= 4'h0;
            end
            ref_sel <= cur_ent[`SAC_ENT_REF_MSB:`SAC_ENT_REF_LSB];
            // Held through the whole sequence, so settings stay frozen
            reference_busy_flag <= busy;
            low_power_bias <= low_rate_power_mode;
        end
    end

    // ==========================================================
    // Window compare on raw codes with one shared threshold pair
    assign is_above = (raw > win_high);
    assign is_below = (raw < win_low);
    // Result is kept only when window compare is off
    assign wr_result = sar_done && !win_enable;
    assign fmt_result = fmt_code(raw, res_bits(res_q), df_q);

    // ==========================================================
    // Result buffers and DMA request
    always @(posedge clk) begin
        if (!rst_b) begin
            for (i_res = 0; i_res < `SAC_NUM_ENT; i_res = i_res + 1) begin
                res_mem_q[i_res] <= `SAC_RES_RST;
            end
            dma_req <= 1'b0;
            rd_data <= `SAC_RES_RST;
        end else begin
            dma_req <= wr_result;
            if (wr_result) begin
                res_mem_q[cur_q] <= fmt_result;
            end
            if (rd_stb) begin
                rd_data <= res_mem_q[rd_idx];
            end
        end
    end

    // ==========================================================
    // Entry flags, a set in the clearing cycle wins
    genvar g;
    generate
        for (g = 0; g < `SAC_NUM_ENT; g = g + 1) begin : g_flag
            always @(posedge clk) begin
                if (!rst_b) begin
                    mem_flag_q[g] <= 1'b0;
                end else if (wr_result && cur_q == g) begin
                    mem_flag_q[g] <= 1'b1;
                end else if (rd_stb && rd_idx == g) begin
                    mem_flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Window flags: bit 0 above, 1 below, 2 inside
    // A vector read clears the window source it reported
    always @(posedge clk) begin
        if (!rst_b) begin
            win_flag_q <= 3'b000;
        end else begin
            for (i_win = 0; i_win < 3; i_win = i_win + 1) begin
                if (sar_done && win_enable &&
                    ((i_win == 0 && is_above) || (i_win == 1 && is_below) ||
                     (i_win == 2 && !is_above && !is_below))) begin
                    win_flag_q[i_win] <= 1'b1;
                end else if (iv_rd_stb &&
                             converter_interrupt_vector ==
                             `SAC_IV_ABOVE + 8'd2 * i_win[7:0]) begin
                    win_flag_q[i_win] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Vector and interrupt line
    assign pending = {mem_flag_q & interrupt_enable_low, win_flag_q & interrupt_enable_high};
    always @(posedge clk) begin
        if (!rst_b) begin
            converter_interrupt_vector <= `SAC_IV_NONE;
        end else begin
            converter_interrupt_vector <= iv_code(pending);
        end
    end
    assign irq = |pending;
    assign interrupt_flag_low = mem_flag_q;
    assign interrupt_flag_high = win_flag_q;
endmodule

// >>> sim/sac_ctrl_sva.sv
// Purpose: port level checks of the converter sequencer
// Assumes: bound to sac_ctrl, single clock domain
// Notes: vector lags the flags by one cycle
`timescale 1ns/1ps
module sac_ctrl_sva #(
    parameter CCLK_DIV = 8
) (
    input wire clk,
    input wire rst_b,
    input wire conv_start,
    input wire low_rate_power_mode,
    input wire win_enable,
    input wire [31:0] interrupt_enable_low,
    input wire [2:0] interrupt_enable_high,
    input wire rd_stb,
    input wire [4:0] rd_idx,
    input wire [7:0] converter_interrupt_vector,
    input wire [31:0] interrupt_flag_low,
    input wire [2:0] interrupt_flag_high,
    input wire irq,
    input wire reference_busy_flag,
    input wire sample_hold,
    input wire low_power_bias,
    input wire dma_req,
    input wire busy,
    input wire seq_done
);
// ==========================================================
// Sample phase run length
reg [7:0] sh_run_q;
always @(posedge clk) begin
    if (!rst_b || !sample_hold) begin
        sh_run_q <= 8'h00;
    end else begin
        sh_run_q <= sh_run_q + 8'h01;
    end
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// ==========================================================
// Assertions, first sample tick may come early in its period
samp_len_a:
    assert property ($fell(sample_hold) |-> sh_run_q > CCLK_DIV && sh_run_q <= 2 * CCLK_DIV)
        else $error("sample phase length wrong");
ref_busy_a:
    assert property (busy |=> reference_busy_flag) else $error("reference busy missing");
ref_free_a:
    assert property (!busy |=> !reference_busy_flag) else $error("reference busy stuck");
start_take_a:
    assert property (conv_start && !busy |=> busy) else $error("start not taken");
lp_bias_a:
    assert property ($past(rst_b) |-> low_power_bias == $past(low_rate_power_mode))
        else $error("power mode not followed");
irq_sum_a:
    assert property (irq == |({interrupt_flag_high, interrupt_flag_low}
        & {interrupt_enable_high, interrupt_enable_low})) else $error("irq sum wrong");
vec_above_a:
    assert property ($past(rst_b) && $past(interrupt_flag_high[0] && interrupt_enable_high[0])
        |-> converter_interrupt_vector == 8'h02) else $error("vector priority wrong");
vec_none_a:
    assert property ($past(rst_b) && !$past(irq) |-> converter_interrupt_vector == 8'h00)
        else $error("vector not idle");
win_drop_a:
    assert property ($past(win_enable, 2) && $past(win_enable) |-> !dma_req
        && (interrupt_flag_low & ~$past(interrupt_flag_low)) == 32'h0)
        else $error("window result stored");
dma_one_a:
    assert property (dma_req |=> !dma_req) else $error("dma request too long");
rd_clr_a:
    assert property (rd_stb && !busy |=> !interrupt_flag_low[$past(rd_idx)])
        else $error("read did not clear flag");
cover property ($rose(interrupt_flag_high[2]));
cover property (seq_done && interrupt_flag_low[31]);
cover property ($rose(dma_req));
endmodule

// >>> sim/sac_ctrl_bench.sv
// Purpose: self checking bench of the converter sequencer
// Assumes: comparator modelled from per channel input table
// Notes: conversion clock divider kept at 8
`timescale 1ns/1ps
module sac_ctrl_bench;
localparam CDIV = 8;
logic clk;
logic rst_b = 0, conv_start = 0, seq_group = 0, result_format_select = 0;
logic low_rate_power_mode = 0, win_enable = 0, ent_wr = 0, rd_stb = 0, iv_rd_stb = 0;
logic comp_in = 0, reference_ready_flag = 1;
logic [4:0] seq_first = 0, ent_idx = 0, rd_idx = 0;
logic [1:0] resolution_select = 0;
logic [11:0] win_high = 0, win_low = 0;
logic [8:0] ent_wdata = 0;
logic [31:0] interrupt_enable_low = 32'hffffffff;
logic [2:0] interrupt_enable_high = 3'h7;
logic [11:0] vtab [0:15];
wire [15:0] rd_data;
wire [7:0] converter_interrupt_vector;
wire [31:0] interrupt_flag_low;
wire [2:0] interrupt_flag_high;
wire [11:0] dac_code;
wire [3:0] mux_pos, mux_neg;
wire mux_diff, mux_internal;
wire [1:0] ref_sel;
wire irq, reference_busy_flag, sample_hold, low_power_bias, dma_req, busy, seq_done;
int n_mismatch = 0, checked = 0, n_dma = 0, n_done = 0;
sac_ctrl #(.CCLK_DIV(CDIV)) dut (
    .clk(clk), .rst_b(rst_b), .conv_start(conv_start), .seq_group(seq_group),
    .seq_first(seq_first), .resolution_select(resolution_select),
    .result_format_select(result_format_select), .low_rate_power_mode(low_rate_power_mode),
    .win_enable(win_enable), .win_high(win_high), .win_low(win_low), .ent_wr(ent_wr),
    .ent_idx(ent_idx), .ent_wdata(ent_wdata), .interrupt_enable_low(interrupt_enable_low),
    .interrupt_enable_high(interrupt_enable_high), .rd_stb(rd_stb), .rd_idx(rd_idx),
    .rd_data(rd_data), .iv_rd_stb(iv_rd_stb),
    .converter_interrupt_vector(converter_interrupt_vector),
    .interrupt_flag_low(interrupt_flag_low), .interrupt_flag_high(interrupt_flag_high),
    .irq(irq), .comp_in(comp_in), .reference_ready_flag(reference_ready_flag),
    .reference_busy_flag(reference_busy_flag), .sample_hold(sample_hold),
    .dac_code(dac_code), .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_diff(mux_diff),
    .mux_internal(mux_internal),
    .ref_sel(ref_sel), .low_power_bias(low_power_bias), .dma_req(dma_req), .busy(busy),
    .seq_done(seq_done)
);
// ==========================================================
// Clock, comparator model and event counters
initial begin
    clk = 0;
    forever #2 clk = ~clk;
end
always @(posedge clk) begin
    comp_in <= #1 (vtab[mux_pos] >= dac_code);
    if (dma_req === 1'b1) n_dma++;
    if (seq_done === 1'b1) n_done++;
end
// ==========================================================
// Shared tasks
task close_out;
    $display("mismatches %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask
task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task put(input logic [4:0] i, input logic [8:0] d);
    ent_idx = i;
    ent_wdata = d;
    ent_wr = 1;
    tick(1);
    ent_wr = 0;
    tick(1);
endtask
task start(input logic g, input logic [4:0] f);
    seq_group = g;
    seq_first = f;
    conv_start = 1;
    tick(1);
    conv_start = 0;
endtask
task rd(input logic [4:0] i, output logic [15:0] d);
    rd_idx = i;
    rd_stb = 1;
    tick(1);
    rd_stb = 0;
    tick(1);
    d = rd_data;
endtask
// Counts clk cycles after the sample phase, start phase varies
task wait_done(output int cyc);
    int w;
    logic seen;
    cyc = 0;
    seen = 0;
    for (w = 0; seq_done !== 1'b1; w++) begin
        if (w > 4000) begin
            n_mismatch++;
            close_out();
        end
        if (sample_hold === 1'b1) seen = 1;
        else if (seen) cyc++;
        tick(1);
    end
endtask
// ==========================================================
// Scenarios
task t_res;
    int c[3];
    int n0;
    logic [15:0] d, e, m;
    n0 = n_dma;
    vtab[3] = 12'hb6d;
    put(5'd0, 9'h103);
    for (int f = 0; f < 2; f++) begin
        for (int r = 0; r < 3; r++) begin
            resolution_select = 2'(r);
            result_format_select = (f == 1);
            start(1'b0, 5'd0);
            wait_done(c[r]);
            chk(16'(interrupt_flag_low[0]), 16'h1);
            tick(1);
            chk(16'(converter_interrupt_vector), 16'h8);
            m = 16'h1 << (7 + 2 * r);
            e = 16'(12'hb6d >> (4 - 2 * r));
            if (f == 1) begin
                e = e ^ m;
                if ((e & m) != 16'h0) e = e | ~((m << 1) - 16'h1);
            end
            rd(5'd0, d);
            chk(d, e);
            chk(16'(interrupt_flag_low[0]), 16'h0);
        end
        chk(16'(c[1] - c[0]), 16'(2 * CDIV));
        chk(16'(c[2] - c[1]), 16'(2 * CDIV));
    end
    chk(16'(n_dma - n0), 16'h6);
endtask
task t_group;
    int c;
    logic [15:0] d;
    vtab[15] = 12'h123;
    vtab[2] = 12'h7fe;
    vtab[9] = 12'hf01;
    resolution_select = 2'b10;
    result_format_select = 0;
    put(5'd29, 9'h00f);
    put(5'd30, 9'h022);
    put(5'd31, 9'h009); // No end mark, last entry ends it
    start(1'b1, 5'd29);
    wait_done(c);
    chk(16'(interrupt_flag_low[31:29]), 16'h7);
    rd(5'd29, d);
    chk(d, 16'h0123);
    chk(16'(converter_interrupt_vector), 16'h44);
    rd(5'd30, d);
    chk(d, 16'h07fe);
    rd(5'd31, d);
    chk(d, 16'h0f01);
endtask
task t_window;
    int c;
    int n0;
    logic [7:0] ev [0:2];
    ev = '{8'h04, 8'h06, 8'h00};
    n0 = n_dma;
    vtab[4] = 12'h3ff;
    vtab[5] = 12'h800;
    vtab[6] = 12'h801;
    win_low = 12'h400;
    win_high = 12'h800;
    win_enable = 1;
    put(5'd1, 9'h004);
    put(5'd2, 9'h005);
    put(5'd3, 9'h106);
    start(1'b1, 5'd1);
    wait_done(c);
    tick(1);
    chk(16'(interrupt_flag_high), 16'h7);
    chk(16'(|interrupt_flag_low), 16'h0);
    chk(16'(n_dma - n0), 16'h0);
    chk(16'(converter_interrupt_vector), 16'h02);
    for (int i = 0; i < 3; i++) begin
        iv_rd_stb = 1;
        tick(1);
        iv_rd_stb = 0;
        tick(1);
        chk(16'(converter_interrupt_vector), 16'(ev[i]));
    end
    win_enable = 0;
endtask
task t_ref;
    int c;
    int d0;
    logic [15:0] d;
    d0 = n_done;
    vtab[11] = 12'h5a5;
    reference_ready_flag = 0;
    put(5'd7, 9'h14b);
    // Let the low ready level pass the synchroniser before starting
    tick(4);
    start(1'b0, 5'd7);
    tick(30);
    chk(16'(busy), 16'h1);
    chk(16'(sample_hold), 16'h0);
    chk(16'(reference_busy_flag), 16'h1);
    chk(16'(ref_sel), 16'h1);
    start(1'b0, 5'd0); // Must be ignored while running
    reference_ready_flag = 1;
    wait_done(c);
    tick(300);
    chk(16'(n_done - d0), 16'h1);
    chk(16'(reference_busy_flag), 16'h0);
    rd(5'd7, d);
    chk(d, 16'h05a5);
    low_rate_power_mode = 1;
    tick(2);
    chk(16'(low_power_bias), 16'h1);
    // Idle mux follows the entry last used, here entry 7
    put(5'd7, 9'h02b);
    chk(16'({mux_diff, mux_neg, mux_pos}), 16'h1ba);
    put(5'd7, 9'h030);
    chk(16'({mux_internal, mux_diff}), 16'h2);
endtask
// ==========================================================
// Main sequence
initial begin
    for (int i = 0; i < 16; i++) vtab[i] = 12'h000;
    tick(2);
    rst_b = 1;
    tick(1);
    t_res();
    t_group();
    t_window();
    t_ref();
    close_out();
end
endmodule
bind sac_ctrl sac_ctrl_sva #(.CCLK_DIV(CCLK_DIV)) u_sva (
    .clk(clk), .rst_b(rst_b), .conv_start(conv_start),
    .low_rate_power_mode(low_rate_power_mode), .win_enable(win_enable),
    .interrupt_enable_low(interrupt_enable_low), .interrupt_enable_high(interrupt_enable_high),
    .rd_stb(rd_stb), .rd_idx(rd_idx), .converter_interrupt_vector(converter_interrupt_vector),
    .interrupt_flag_low(interrupt_flag_low), .interrupt_flag_high(interrupt_flag_high),
    .irq(irq), .reference_busy_flag(reference_busy_flag), .sample_hold(sample_hold),
    .low_power_bias(low_power_bias), .dma_req(dma_req), .busy(busy), .seq_done(seq_done)
);
